// ### design/eifs_pkg.sv
package eifs_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int GLITCH_FILTER_WIDTH_NS = 100;
	// Two extra samples so that a pulse of the full width is never seen as stable
	localparam int GLITCH_FILTER_CYC = GLITCH_FILTER_WIDTH_NS / CLK_PERIOD_NS + 2;
	localparam int POWER_UP_DELAY_US = 1000;
	localparam int NS_PER_US = 1000;
	// Longest time, so rounded down
	localparam int POWER_UP_CYC = POWER_UP_DELAY_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int PIN_STABLE_CYC = 1;

	// ****************************************************************
	// Slave address layout and fixed values
	// ****************************************************************
	localparam int ADDR_TYPE_MSB = 7;
	localparam int ADDR_TYPE_LSB = 4;
	localparam int ADDR_STRAP_MSB = 3;
	localparam int ADDR_STRAP_LSB = 1;
	localparam int ADDR_RW_BIT = 0;
	localparam int BYTE_MSB = 7;
	// Arbitrary device-type code, not tied to any real part
	localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h6;
	localparam logic [2:0] FIXED_STRAPS = 3'h0;
	localparam logic WP_INACTIVE = 1'h0;
	localparam logic RW_READ = 1'h1;
	localparam logic SDA_DRIVE_LEVEL = 1'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] FIRST_TX_BIT = 4'h1;
	localparam logic [1:0] FIRST_DATA_IDX = 2'h2;
	localparam logic [1:0] LAST_BYTE_IDX = 2'h3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_ADDR_ACK = 4'h3,
		ST_RX = 4'h4,
		ST_RX_ACK = 4'h5,
		ST_TX_WAIT = 4'h6,
		ST_TX = 4'h7,
		ST_TX_ACK = 4'h8,
		ST_IGNORE = 4'h9
	} eifs_state_t;

	typedef enum logic [2:0] {
		EVT_ADDR_WR = 3'h0,
		EVT_ADDR_RD = 3'h1,
		EVT_RX_BYTE = 3'h2,
		EVT_STOP = 3'h3,
		EVT_WP_REJECT = 3'h4
	} eifs_evt_kind_t;

	typedef struct packed {
		eifs_evt_kind_t kind;
		logic [7:0] data;
	} eifs_evt_t;

endpackage : eifs_pkg

// ### design/eifs_pin_filter.sv
`timescale 1ns/10ps
`default_nettype none
module eifs_pin_filter #(
	parameter int WIDTH = 1,
	parameter int STABLE_CYC = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	localparam int CNT_W = $clog2(STABLE_CYC + 1);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] hold_ff;
	logic [WIDTH-1:0] level_ff;
	logic [CNT_W-1:0] cnt_ff;

	// Three-stage synchroniser; only the second stage reads the first
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta_ff <= RESET_LEVEL;
			sync_ff <= RESET_LEVEL;
			hold_ff <= RESET_LEVEL;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
			hold_ff <= sync_ff;
		end
	end

	// Level follows only after stages two and three agree for STABLE_CYC samples
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cnt_ff <= '0;
			level_ff <= RESET_LEVEL;
		end else if (sync_ff != hold_ff || hold_ff == level_ff) begin
			cnt_ff <= '0; // Short pulse restarts the count
		end else if (cnt_ff == CNT_W'(STABLE_CYC - 1)) begin
			cnt_ff <= '0;
			level_ff <= hold_ff;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign o_level = level_ff;

	chk_filter_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$changed(level_ff) |-> $past(cnt_ff) == CNT_W'(STABLE_CYC - 1))
		else $error("filtered level changed before the stable count");

endmodule : eifs_pin_filter
`default_nettype wire

// ### design/eifs_event_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eifs_event_sync (
	input wire logic i_src_clk,
	input wire logic i_src_reset_n,
	input wire logic i_src_pulse,
	input wire logic i_dst_clk,
	input wire logic i_dst_reset_n,
	output logic o_dst_pulse
);
	logic toggle_ff;
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// Event becomes a level change so it survives any clock ratio
	always_ff @(posedge i_src_clk) begin
		if (!i_src_reset_n) begin
			toggle_ff <= 1'b0;
		end else if (i_src_pulse) begin
			toggle_ff <= ~toggle_ff;
		end
	end

	// Three stages; the pulse is taken where stages two and three differ
	always_ff @(posedge i_dst_clk) begin
		if (!i_dst_reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= toggle_ff;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign o_dst_pulse = sync_ff ^ last_ff;

endmodule : eifs_event_sync
`default_nettype wire

// ### design/eifs_front_end.sv
// What this block does
// - Reset input holds device in reset; release leads to standby.
// - Device accepts bus commands within power-up delay after reset release.
// - Pulses up to 100 ns on clock and data are ignored.
// - Data pin is open drain: pulled low or released, never driven high.
// - Incoming bits sampled on clock rise; outgoing bits change after clock fall.
// - Three address bits must match the chip-select strap inputs.
// - Write-protect high refuses writes; low allows them.
// - Build without straps answers only straps 000 and allows all writes.
// - Zero is line pulled low; one is line released high.
// - Data stays stable while clock high; changes only while clock low.
// - Start is data falling with clock high; nothing answered without it.
// - Stop is data rising with clock high; it ends the command.
// - Address byte: type code, straps high to low, then direction.
// - Last address bit one means read, zero means write.
// - Transmitter releases data in ninth clock; receiver low acks.
// - While internal write runs, no address is acknowledged.
// - Write protect strobed on fall before first data byte; high rejects.
`timescale 1ns/10ps
`default_nettype none
module eifs_front_end import eifs_pkg::*; #(
	parameter bit HAS_STRAP_PINS = 1'b1,
	parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEFAULT,
	parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic [2:0] i_chip_select_straps,
	input wire logic i_write_protect,
	output logic o_ready,
	input wire logic i_core_clk,
	input wire logic i_core_reset_n,
	input wire logic i_core_write_busy,
	output eifs_evt_t o_core_evt,
	output logic o_core_evt_valid,
	output logic o_core_tx_req,
	input wire logic i_core_tx_valid,
	input wire logic [7:0] i_core_tx_byte
);
	localparam int PU_W = $clog2(POWER_UP_CYCLES + 1);

	// ****************************************************************
	// Pin conditioning
	// ****************************************************************
	logic scl_f;
	logic sda_f;
	logic [3:0] strap_wp_s;
	logic busy_s;

	// Clock is input only; the master alone drives it
	eifs_pin_filter #(.WIDTH(1), .STABLE_CYC(GLITCH_FILTER_CYC), .RESET_LEVEL(1'b1)) u_scl_filt (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_scl),
		.o_level(scl_f)
	);

	eifs_pin_filter #(.WIDTH(1), .STABLE_CYC(GLITCH_FILTER_CYC), .RESET_LEVEL(1'b1)) u_sda_filt (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_sda),
		.o_level(sda_f)
	);

	eifs_pin_filter #(.WIDTH(4), .STABLE_CYC(PIN_STABLE_CYC), .RESET_LEVEL(4'h0)) u_strap_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin({i_write_protect, i_chip_select_straps}),
		.o_level(strap_wp_s)
	);

	eifs_pin_filter #(.WIDTH(1), .STABLE_CYC(PIN_STABLE_CYC), .RESET_LEVEL(1'b0)) u_busy_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_core_write_busy),
		.o_level(busy_s)
	);

	// Build without pins answers only the fixed straps and never write-protects
	logic [2:0] straps_eff;
	logic wp_eff;
	assign straps_eff = HAS_STRAP_PINS ? strap_wp_s[2:0] : FIXED_STRAPS;
	assign wp_eff = HAS_STRAP_PINS ? strap_wp_s[3] : WP_INACTIVE;

	// ****************************************************************
	// Power-up
	// ****************************************************************
	logic [PU_W-1:0] pu_cnt_ff;
	logic ready_ff;

	// Reset stands for supply below trigger; count out the delay before standby
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pu_cnt_ff <= '0;
			ready_ff <= 1'b0;
		end else if (!ready_ff) begin
			if (pu_cnt_ff == PU_W'(POWER_UP_CYCLES - 1)) begin
				ready_ff <= 1'b1;
			end else begin
				pu_cnt_ff <= pu_cnt_ff + 1'b1;
			end
		end
	end

	assign o_ready = ready_ff;

	// ****************************************************************
	// Bus conditions
	// ****************************************************************
	logic scl_d_ff;
	logic sda_d_ff;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_f;
			sda_d_ff <= sda_f;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_f & ~scl_d_ff;
	assign scl_fall = ~scl_f & scl_d_ff;
	// Data edges while clock stays high are conditions, not bits
	assign start_det = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
	assign stop_det = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

	// ****************************************************************
	// Protocol engine
	// ****************************************************************
	eifs_state_t state_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic rw_ff;
	logic [1:0] byte_idx_ff;
	logic wp_lock_ff;
	logic master_ack_ff;
	logic session_ff;
	logic sda_oe_ff;
	logic tx_ack_pulse;
	logic [7:0] tx_byte_core_ff;

	logic on_bus;
	logic byte_end;
	logic addr_match;
	logic data_byte;
	logic reject;
	assign on_bus = ready_ff & ~start_det & ~stop_det;
	assign byte_end = scl_fall && bit_cnt_ff == BITS_PER_BYTE;
	// Type code, straps in order, then direction; busy hides the device
	assign addr_match = shift_ff[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEVICE_TYPE
		&& shift_ff[ADDR_STRAP_MSB:ADDR_STRAP_LSB] == straps_eff && !busy_s;
	assign data_byte = byte_idx_ff >= FIRST_DATA_IDX;
	assign reject = data_byte && wp_lock_ff;

	// Start and stop override any state; apart from ST_RESET and ST_TX_WAIT, all else moves on filtered clock edges
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_ff <= ST_RESET;
			bit_cnt_ff <= '0;
			shift_ff <= '0;
			rw_ff <= 1'b0;
			byte_idx_ff <= '0;
			wp_lock_ff <= 1'b0;
			master_ack_ff <= 1'b0;
			session_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (!ready_ff) begin
			state_ff <= ST_RESET;
			sda_oe_ff <= 1'b0;
		end else if (start_det) begin
			state_ff <= ST_ADDR;
			bit_cnt_ff <= '0;
			session_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= ST_IDLE;
			session_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_RESET: begin
					state_ff <= ST_IDLE;
				end
				ST_IDLE, ST_IGNORE: begin
					sda_oe_ff <= 1'b0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_ff <= {shift_ff[BYTE_MSB-1:0], sda_f};
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
					end else if (byte_end && state_ff == ST_ADDR) begin
						if (addr_match) begin
							sda_oe_ff <= 1'b1;
							rw_ff <= shift_ff[ADDR_RW_BIT];
							byte_idx_ff <= '0;
							wp_lock_ff <= 1'b0;
							session_ff <= 1'b1;
							state_ff <= ST_ADDR_ACK;
						end else begin
							state_ff <= ST_IGNORE;
						end
					end else if (byte_end) begin
						if (reject) begin
							state_ff <= ST_IGNORE;
						end else begin
							sda_oe_ff <= 1'b1;
							state_ff <= ST_RX_ACK;
							if (byte_idx_ff != LAST_BYTE_IDX) begin
								byte_idx_ff <= byte_idx_ff + 1'b1;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_fall) begin
						sda_oe_ff <= 1'b0;
						bit_cnt_ff <= '0;
						if (state_ff == ST_RX_ACK && byte_idx_ff == FIRST_DATA_IDX) begin
							wp_lock_ff <= wp_eff;
						end
						state_ff <= (state_ff == ST_ADDR_ACK && rw_ff == RW_READ) ? ST_TX_WAIT : ST_RX;
					end
				end
				ST_TX_WAIT: begin
					if (tx_ack_pulse) begin
						shift_ff <= tx_byte_core_ff;
						sda_oe_ff <= ~tx_byte_core_ff[BYTE_MSB];
						bit_cnt_ff <= FIRST_TX_BIT;
						state_ff <= ST_TX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_ff == BITS_PER_BYTE) begin
							sda_oe_ff <= 1'b0;
							state_ff <= ST_TX_ACK;
						end else begin
							shift_ff <= {shift_ff[BYTE_MSB-1:0], 1'b0};
							sda_oe_ff <= ~shift_ff[BYTE_MSB-1];
							bit_cnt_ff <= bit_cnt_ff + 1'b1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						master_ack_ff <= ~sda_f;
					end else if (scl_fall) begin
						state_ff <= master_ack_ff ? ST_TX_WAIT : ST_IGNORE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: the output value is always low, only the enable moves
	assign o_sda_out = SDA_DRIVE_LEVEL;
	assign o_sda_oe = sda_oe_ff;

	// ****************************************************************
	// Events toward the memory core
	// ****************************************************************
	eifs_evt_t evt_ff;
	logic evt_pulse_ff;
	logic tx_req_pulse;

	// Event word stays put until the next event, many clocks later
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			evt_ff <= '{kind: EVT_ADDR_WR, data: 8'h00};
			evt_pulse_ff <= 1'b0;
		end else begin
			evt_pulse_ff <= 1'b0;
			if (on_bus && state_ff == ST_ADDR && byte_end && addr_match) begin
				evt_ff <= '{kind: shift_ff[ADDR_RW_BIT] ? EVT_ADDR_RD : EVT_ADDR_WR, data: shift_ff};
				evt_pulse_ff <= 1'b1;
			end else if (on_bus && state_ff == ST_RX && byte_end) begin
				evt_ff <= '{kind: reject ? EVT_WP_REJECT : EVT_RX_BYTE, data: shift_ff};
				evt_pulse_ff <= 1'b1;
			end else if (ready_ff && stop_det && session_ff) begin
				evt_ff <= '{kind: EVT_STOP, data: 8'h00};
				evt_pulse_ff <= 1'b1;
			end
		end
	end

	assign tx_req_pulse = on_bus && scl_fall
		&& ((state_ff == ST_ADDR_ACK && rw_ff == RW_READ) || (state_ff == ST_TX_ACK && master_ack_ff));

	logic core_evt_pulse;
	logic core_tx_req_pulse;
	logic core_tx_ack_ff;

	eifs_event_sync u_evt_sync (
		.i_src_clk(i_clk),
		.i_src_reset_n(i_reset_n),
		.i_src_pulse(evt_pulse_ff),
		.i_dst_clk(i_core_clk),
		.i_dst_reset_n(i_core_reset_n),
		.o_dst_pulse(core_evt_pulse)
	);

	eifs_event_sync u_req_sync (
		.i_src_clk(i_clk),
		.i_src_reset_n(i_reset_n),
		.i_src_pulse(tx_req_pulse),
		.i_dst_clk(i_core_clk),
		.i_dst_reset_n(i_core_reset_n),
		.o_dst_pulse(core_tx_req_pulse)
	);

	eifs_event_sync u_ack_sync (
		.i_src_clk(i_core_clk),
		.i_src_reset_n(i_core_reset_n),
		.i_src_pulse(core_tx_ack_ff),
		.i_dst_clk(i_clk),
		.i_dst_reset_n(i_reset_n),
		.o_dst_pulse(tx_ack_pulse)
	);

	// ****************************************************************
	// Core clock side
	// ****************************************************************
	eifs_evt_t core_evt_ff;
	logic core_evt_valid_ff;
	logic core_tx_req_ff;
	logic tx_pend_ff;

	// Captured only on the synchronised pulse, when the word is settled
	always_ff @(posedge i_core_clk) begin
		if (!i_core_reset_n) begin
			core_evt_ff <= '{kind: EVT_ADDR_WR, data: 8'h00};
			core_evt_valid_ff <= 1'b0;
		end else begin
			core_evt_valid_ff <= core_evt_pulse;
			if (core_evt_pulse) begin
				core_evt_ff <= evt_ff;
			end
		end
	end

	// Read byte handshake; a byte offered without a request is dropped
	always_ff @(posedge i_core_clk) begin
		if (!i_core_reset_n) begin
			core_tx_req_ff <= 1'b0;
			tx_pend_ff <= 1'b0;
			core_tx_ack_ff <= 1'b0;
			tx_byte_core_ff <= 8'h00;
		end else begin
			core_tx_req_ff <= core_tx_req_pulse;
			core_tx_ack_ff <= 1'b0;
			if (core_tx_req_pulse) begin
				tx_pend_ff <= 1'b1;
			end else if (tx_pend_ff && i_core_tx_valid) begin
				tx_pend_ff <= 1'b0;
				tx_byte_core_ff <= i_core_tx_byte;
				core_tx_ack_ff <= 1'b1;
			end
		end
	end

	assign o_core_evt = core_evt_ff;
	assign o_core_evt_valid = core_evt_valid_ff;
	assign o_core_tx_req = core_tx_req_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking chk_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	chk_quiet_before_ready: assert property (!ready_ff |-> !o_sda_oe && state_ff == ST_RESET)
		else $error("device active before power-up delay");
	chk_ready_time: assert property ($rose(ready_ff) |-> $past(pu_cnt_ff) == PU_W'(POWER_UP_CYCLES - 1))
		else $error("ready raised at wrong count");
	chk_sda_change_low: assert property ($changed(sda_oe_ff) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_f))
		else $error("data output changed while clock high");
	chk_idle_released: assert property (state_ff == ST_IDLE || state_ff == ST_IGNORE |=> !o_sda_oe || start_det)
		else $error("data driven while not addressed");
	chk_start_addr: assert property (ready_ff && start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'h0 && !o_sda_oe)
		else $error("start did not open address phase");
	chk_stop_idle: assert property (ready_ff && stop_det |=> state_ff == ST_IDLE ##1 !o_sda_oe)
		else $error("stop did not end command");
	chk_busy_no_ack: assert property (on_bus && state_ff == ST_ADDR && byte_end && busy_s |=> state_ff == ST_IGNORE && !o_sda_oe)
		else $error("address acknowledged during write cycle");
	chk_wp_nack: assert property (on_bus && state_ff == ST_RX && byte_end && reject |=> !o_sda_oe [*2])
		else $error("protected data byte acknowledged");
	chk_type_mismatch: assert property (on_bus && state_ff == ST_ADDR && byte_end
		&& shift_ff[ADDR_TYPE_MSB:ADDR_TYPE_LSB] != DEVICE_TYPE |=> state_ff == ST_IGNORE)
		else $error("foreign address not ignored");
	chk_ack_release: assert property (on_bus && state_ff == ST_ADDR_ACK && scl_fall |=> !o_sda_oe || state_ff == ST_TX)
		else $error("ack not released after ninth clock");

	cov_write_ack: cover property (state_ff == ST_RX_ACK && data_byte);
	cov_read_byte: cover property (state_ff == ST_TX ##[1:1000] state_ff == ST_TX_ACK);
	cov_wp_reject: cover property (on_bus && state_ff == ST_RX && byte_end && reject);
	cov_busy_poll: cover property (on_bus && state_ff == ST_ADDR && byte_end && busy_s);

endmodule : eifs_front_end
`default_nettype wire

// ### test/eifs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Two-wire bus master model
// ********
module eifs_master_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	// Bus idles released, clock high
	initial begin
		o_scl = 1'h1;
		o_sda_low = 1'h0;
	end
	// Wait whole system clocks
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tk
	// Data set long after the fall so the slave's filter sees no fake edge
	task automatic put_bit(input logic b);
		o_scl <= 1'h0;
		tk(25);
		o_sda_low <= ~b;
		tk(75);
		o_scl <= 1'h1;
		tk(60);
	endtask : put_bit
	// Released line is read mid-high, after the slave's filter has seen the rise
	task automatic get_bit(output logic b);
		o_scl <= 1'h0;
		tk(25);
		o_sda_low <= 1'h0;
		tk(75);
		o_scl <= 1'h1;
		tk(30);
		b = i_sda;
		tk(30);
	endtask : get_bit
	// Only called on an idle bus, so the gap before it is the free time
	task automatic start();
		o_sda_low <= 1'h0;
		tk(100);
		o_sda_low <= 1'h1;
		tk(60);
	endtask : start
	task automatic stop();
		put_bit(1'h0);
		o_sda_low <= 1'h0;
		tk(100);
	endtask : stop
	// Short pulses on both lines, below the filter width
	task automatic glitch();
		o_scl <= 1'h0;
		tk(10);
		o_scl <= 1'h1;
		tk(20);
		o_sda_low <= 1'h1;
		tk(10);
		o_sda_low <= 1'h0;
		tk(50);
	endtask : glitch
	// Address and data go out MSB first
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(~ack);
	endtask : rbyte
endmodule : eifs_master_model
`default_nettype wire

// ### test/eifs_front_end_tb.sv
`timescale 1ns/10ps
`default_nettype none
module eifs_front_end_tb import eifs_pkg::*; ;
	logic clk, cclk, rst_n, scl, m_low, oe, so, rdy, ev_v, tx_req, tx_v, wp, busy, k;
	logic [2:0] straps, s;
	logic [7:0] tx_b;
	eifs_evt_t ev;
	eifs_evt_t exp_q[$];
	logic [7:0] rd_q[$];
	int seed, n_mismatch, checks_done, n;
	wire logic sda;
	// Wired-and line with pull-up
	assign sda = m_low ? 1'h0 : (oe ? so : 1'h1);
	eifs_master_model m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
	eifs_front_end #(.POWER_UP_CYCLES(50)) dut (.i_clk(clk), .i_reset_n(rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe),
		.i_chip_select_straps(straps), .i_write_protect(wp), .o_ready(rdy),
		.i_core_clk(cclk), .i_core_reset_n(rst_n), .i_core_write_busy(busy),
		.o_core_evt(ev), .o_core_evt_valid(ev_v), .o_core_tx_req(tx_req),
		.i_core_tx_valid(tx_v), .i_core_tx_byte(tx_b));
	// Clocks, core clock off in phase
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		cclk = 1'h0;
		#3.3;
		forever #7.5 cclk = ~cclk;
	end
	// ********
	// Compare tasks
	// ********
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic cmp_ack(input logic g, input logic e);
		chk({10'h000, g}, {10'h000, e});
	endtask : cmp_ack
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		chk({3'h0, g}, {3'h0, e});
	endtask : cmp_byte
	task automatic cmp_evt(input eifs_evt_t g, input eifs_evt_t e);
		chk(g, e);
	endtask : cmp_evt
	task automatic final_report();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	function automatic logic [7:0] adr(input logic [2:0] st, input logic rw);
		return {DEVICE_TYPE_DEFAULT, st, rw};
	endfunction : adr
	// ********
	// Transfers with expected events queued
	// ********
	task automatic wr(input logic [7:0] a, input logic aa, input int nd);
		logic ak;
		logic [7:0] b;
		m.start();
		// Expected event is queued before the byte, as the event beats the ack bit's end
		if (aa) exp_q.push_back('{EVT_ADDR_WR, 8'h00});
		m.wbyte(a, ak);
		cmp_ack(ak, aa);
		for (int i = 0; i < nd && aa; i++) begin
			b = 8'($random(seed));
			exp_q.push_back('{(i >= 2 && wp) ? EVT_WP_REJECT : EVT_RX_BYTE, b});
			m.wbyte(b, ak);
			cmp_ack(ak, i < 2 || !wp);
			if (i >= 2 && wp) break;
		end
		if (aa && !(wp && nd > 2)) exp_q.push_back('{EVT_STOP, 8'h00});
		m.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic aa, input int nr);
		logic ak;
		logic [7:0] b;
		m.start();
		if (aa) exp_q.push_back('{EVT_ADDR_RD, 8'h00});
		m.wbyte(a, ak);
		cmp_ack(ak, aa);
		for (int i = 0; i < nr && aa; i++) begin
			m.rbyte(b, i < nr - 1);
			cmp_byte(b, rd_q.size() ? rd_q.pop_front() : ~b);
		end
		m.stop();
	endtask : rd
	// Core side answers requests at once; a stop after a read is optional
	always @(posedge cclk) begin
		eifs_evt_t g;
		eifs_evt_t e;
		logic [7:0] b;
		tx_v <= 1'h0;
		tx_b <= 8'($random(seed));
		if (tx_req === 1'h1) begin
			b = 8'($random(seed));
			tx_v <= 1'h1;
			tx_b <= b;
			rd_q.push_back(b);
		end
		g = ev;
		if (g.kind != EVT_RX_BYTE && g.kind != EVT_WP_REJECT) g.data = 8'h00;
		e = exp_q.size() ? exp_q[0] : ~g;
		if (ev_v === 1'h1 && !(g.kind === EVT_STOP && e.kind !== EVT_STOP)) begin
			cmp_evt(g, e);
			if (exp_q.size()) void'(exp_q.pop_front());
		end
	end
	// Device may only pull the line low
	always @(posedge clk) if (oe === 1'h1) cmp_ack(so, 1'h0);
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	// ********
	// Main sequence
	// ********
	initial begin
		seed = 45812;
		n_mismatch = 0;
		checks_done = 0;
		rst_n = 1'h0;
		wp = 1'h0;
		busy = 1'h0;
		tx_v = 1'h0;
		tx_b = 8'h00;
		straps = 3'h0;
		s = 3'($random(seed));
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		straps <= s;
		n = 0;
		while (rdy !== 1'h1 && n < 200) begin
			@(posedge clk);
			n++;
			#1;
		end
		cmp_byte(n[7:0], 8'h32);
		m.glitch();
		m.wbyte(adr(s, 1'h0), k);
		cmp_ack(k, 1'h0);
		m.stop();
		wr(adr(s, 1'h0), 1'h1, 3);
		rd(adr(s, 1'h1), 1'h1, 2);
		for (int j = 0; j < 3; j++) wr(adr(s ^ (3'h1 << j), 1'h0), 1'h0, 1);
		rd({~DEVICE_TYPE_DEFAULT, s, 1'h1}, 1'h0, 1);
		wp <= 1'h1;
		wr(adr(s, 1'h0), 1'h1, 3);
		wp <= 1'h0;
		busy <= 1'h1;
		wr(adr(s, 1'h0), 1'h0, 1);
		rd(adr(s, 1'h1), 1'h0, 1);
		busy <= 1'h0;
		wr(adr(s, 1'h0), 1'h1, 1);
		repeat (100) @(posedge clk);
		cmp_byte(8'(exp_q.size()), 8'h00);
		cmp_byte(8'(rd_q.size()), 8'h00);
		final_report();
	end
endmodule : eifs_front_end_tb
`default_nettype wire
